// file: rtl/rsmc_consts.svh
`ifndef RSMC_CONSTS_SVH
`define RSMC_CONSTS_SVH

// register addresses (8-bit register space)
`define RSMC_ADDR_SUPPLY_MON 8'hff
`define RSMC_ADDR_RESET_CAUSE 8'hef
`define RSMC_ADDR_PWR_MODE 8'hd4

// supply monitor control fields
`define RSMC_SMC_ON_BIT 7
`define RSMC_SMC_ABOVE_RST_BIT 6
`define RSMC_SMC_WARN_OK_BIT 5
`define RSMC_SMC_WARN_IE_BIT 3

// reset cause fields
`define RSMC_RC_PIN_BIT 0
`define RSMC_RC_POR_BIT 1
`define RSMC_RC_SW_BIT 4
`define RSMC_RC_FERR_BIT 6

// power mode fields
`define RSMC_PM_MONOFF_BIT 5
`define RSMC_PM_SLEEP_BIT 0

// reset values
`define RSMC_SMC_ON_RST 1'b1
`define RSMC_SMC_IE_RST 1'b1
`define RSMC_PC_RESET 16'h0000

// timing
`define RSMC_CLK_NS 10
`define RSMC_POR_LOW_MS 7
`define RSMC_POR_HIGH_MS 15
`define RSMC_POR_LOW_CYC ((`RSMC_POR_LOW_MS * 1000000) / `RSMC_CLK_NS)
`define RSMC_POR_HIGH_CYC ((`RSMC_POR_HIGH_MS * 1000000) / `RSMC_CLK_NS)
`define RSMC_CNT_W 24

`endif

// file: rtl/rsmc_pkg.sv
package rsmc_pkg;
    typedef enum logic [1:0] {
        RSMC_POR = 2'b00,
        RSMC_DELAY = 2'b01,
        RSMC_HOLD = 2'b10,
        RSMC_RUN = 2'b11
    } rsmc_state_t;
endpackage

// file: rtl/rsmc_reset_ctrl.sv
// Our own choice: the strobed register port.
`include "rsmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module rsmc_reset_ctrl
#(
    // release delays in clock cycles, low and high supply range
    parameter int POR_LOW_CYC = `RSMC_POR_LOW_CYC,
    parameter int POR_HIGH_CYC = `RSMC_POR_HIGH_CYC
)
(
    // clock and reset (reset_i stands for the supply crossing power-on level)
    input wire logic clk_i,
    input wire logic reset_i,
    // analog comparators and supply range, as pins
    input wire logic supply_above_reset_level_i,
    input wire logic supply_warning_ok_i,
    input wire logic supply_high_i,
    // external reset pin
    input wire logic rst_pin_n_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    // core events
    input wire logic sleep_i,
    input wire logic flash_wr_i,
    input wire logic monitor_settled_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // core reset and status
    output logic core_reset_o,
    output logic [15:0] pc_start_o,
    output logic ram_invalid_o,
    output logic warn_irq_o
);
    import rsmc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        rsmc_state_t state;
        logic [`RSMC_CNT_W-1:0] cnt;
        logic [1:0] pin_sync;
        logic [1:0] above_sync;
        logic [1:0] warn_sync;
        logic [1:0] high_sync;
        logic warn_prev;
        logic mon_on;
        logic mon_sel;
        logic mon_off;
        logic warn_ie;
        logic por_flag;
        logic pin_flag;
        logic sw_flag;
        logic ferr_flag;
        logic pend_pin;
        logic pend_sw;
        logic pend_ferr;
        logic pend_vdm;
        logic drive_pin;
        logic [1:0] drive_hist;
        logic ram_bad;
        logic irq;
        logic [7:0] rdata;
    } rsmc_regs_t;

    rsmc_regs_t s_reg;
    rsmc_regs_t s_next;

    logic pin_low;
    logic vdm_fail;
    logic sys_rst;
    logic [`RSMC_CNT_W-1:0] por_cnt;
    logic [7:0] smc_view;
    logic [7:0] rc_view;

    // ****************************************
    // decode
    // ****************************************
    // synchronised pin level, asserted from the second sync stage two clocks after the pin
    assign pin_low = !s_reg.pin_sync[1];
    // monitor fires only enabled, selected and awake
    assign vdm_fail = s_reg.mon_on && s_reg.mon_sel && !sleep_i
        && !s_reg.above_sync[1];
    // software reset is requested here
    assign sys_rst = wr_i && (addr_i == `RSMC_ADDR_RESET_CAUSE)
        && wdata_i[`RSMC_RC_SW_BIT];
    // delay picks range by supply level
    assign por_cnt = s_reg.high_sync[1]
        ? `RSMC_CNT_W'(POR_HIGH_CYC)
        : `RSMC_CNT_W'(POR_LOW_CYC);

    // register views
    always_comb
    begin
        smc_view = 8'h00;
        smc_view[`RSMC_SMC_ON_BIT] = s_reg.mon_on;
        smc_view[`RSMC_SMC_ABOVE_RST_BIT] = s_reg.above_sync[1];
        smc_view[`RSMC_SMC_WARN_OK_BIT] = s_reg.warn_sync[1];
        smc_view[`RSMC_SMC_WARN_IE_BIT] = s_reg.warn_ie;
        rc_view = 8'h00;
        rc_view[`RSMC_RC_PIN_BIT] = s_reg.pin_flag;
        rc_view[`RSMC_RC_POR_BIT] = s_reg.por_flag;
        rc_view[`RSMC_RC_SW_BIT] = s_reg.sw_flag;
        rc_view[`RSMC_RC_FERR_BIT] = s_reg.ferr_flag;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.pin_sync = {s_reg.pin_sync[0], rst_pin_n_i};
        s_next.above_sync = {s_reg.above_sync[0], supply_above_reset_level_i};
        s_next.drive_hist = {s_reg.drive_hist[0], s_reg.drive_pin};
        s_next.warn_sync = {s_reg.warn_sync[0], supply_warning_ok_i};
        s_next.high_sync = {s_reg.high_sync[0], supply_high_i};
        s_next.warn_prev = s_reg.warn_sync[1];
        // falling warning raises a pulse when enabled
        s_next.irq = s_reg.warn_ie && s_reg.warn_prev
            && !s_reg.warn_sync[1];
        s_next.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `RSMC_ADDR_SUPPLY_MON: s_next.rdata = smc_view;
                `RSMC_ADDR_RESET_CAUSE: s_next.rdata = rc_view;
                `RSMC_ADDR_PWR_MODE:
                    s_next.rdata = {2'b00, s_reg.mon_off, 5'h00};
                default: s_next.rdata = 8'h00;
            endcase
        end
        case (s_reg.state)
            RSMC_POR:
            begin
                // full power-on: monitor defaults restored
                s_next.mon_on = `RSMC_SMC_ON_RST;
                s_next.mon_sel = 1'b1;
                s_next.mon_off = 1'b0;
                s_next.warn_ie = `RSMC_SMC_IE_RST;
                s_next.ram_bad = 1'b1;
                s_next.pend_vdm = 1'b0;
                s_next.pend_pin = 1'b0;
                s_next.pend_sw = 1'b0;
                s_next.pend_ferr = 1'b0;
                s_next.drive_pin = 1'b0;
                s_next.cnt = '0;
                s_next.state = RSMC_DELAY;
            end
            RSMC_DELAY:
            begin
                // count up against the synchronised supply range, so the
                // range pick sees the cleared sync stages only while the count is zero
                s_next.cnt = s_reg.cnt + `RSMC_CNT_W'(1);
                if (s_reg.cnt >= por_cnt - `RSMC_CNT_W'(1))
                begin
                    s_next.por_flag = 1'b1;
                    s_next.pin_flag = 1'b0;
                    s_next.sw_flag = 1'b0;
                    s_next.ferr_flag = 1'b0;
                    s_next.state = RSMC_RUN;
                end
            end
            RSMC_HOLD:
            begin
                // held while the pin is low or a pending monitor reset still sees the supply below reset level
                // pin driven only while supply stays below reset level
                s_next.drive_pin = s_reg.pend_vdm
                    && !s_reg.above_sync[1];
                if (s_reg.pend_vdm)
                begin
                    s_next.mon_on = 1'b1;
                    s_next.mon_sel = 1'b1;
                    s_next.ram_bad = 1'b1;
                end
                // own drive must leave the pin sync stages before release
                if (!pin_low && !s_reg.drive_pin && s_reg.drive_hist == 2'b00
                    && !(s_reg.pend_vdm && !s_reg.above_sync[1]))
                begin
                    // no release delay after monitor reset
                    s_next.drive_pin = 1'b0;
                    s_next.por_flag = s_reg.pend_vdm;
                    s_next.pin_flag = s_reg.pend_pin;
                    s_next.sw_flag = s_reg.pend_sw;
                    s_next.ferr_flag = s_reg.pend_ferr;
                    s_next.pend_vdm = 1'b0;
                    s_next.pend_pin = 1'b0;
                    s_next.pend_sw = 1'b0;
                    s_next.pend_ferr = 1'b0;
                    s_next.state = RSMC_RUN;
                end
            end
            RSMC_RUN:
            begin
                s_next.ram_bad = 1'b0;
                // register writes
                if (wr_i && addr_i == `RSMC_ADDR_SUPPLY_MON)
                begin
                    s_next.mon_on = wdata_i[`RSMC_SMC_ON_BIT];
                    s_next.warn_ie = wdata_i[`RSMC_SMC_WARN_IE_BIT];
                end
                if (wr_i && addr_i == `RSMC_ADDR_RESET_CAUSE)
                    s_next.mon_sel = wdata_i[`RSMC_RC_POR_BIT];
                if (wr_i && addr_i == `RSMC_ADDR_PWR_MODE)
                    s_next.mon_off = wdata_i[`RSMC_PM_MONOFF_BIT];
                // pick a reset source
                if (vdm_fail || pin_low || sys_rst
                    || (flash_wr_i && !s_reg.mon_on))
                begin
                    s_next.pend_vdm = vdm_fail;
                    s_next.pend_pin = pin_low;
                    s_next.pend_sw = sys_rst;
                    s_next.pend_ferr = flash_wr_i && !s_reg.mon_on;
                    // unsettled monitor newly selected behaves as fail
                    if (s_reg.mon_off)
                        s_next.state = RSMC_POR;
                    else
                        s_next.state = RSMC_HOLD;
                end
                else if (wr_i && addr_i == `RSMC_ADDR_RESET_CAUSE
                    && wdata_i[`RSMC_RC_POR_BIT] && !s_reg.mon_sel
                    && !monitor_settled_i)
                begin
                    s_next.pend_vdm = 1'b1;
                    s_next.state = s_reg.mon_off ? RSMC_POR : RSMC_HOLD;
                end
            end
            default: s_next.state = RSMC_POR;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_reg <= '0;
            s_reg.state <= RSMC_POR;
            s_reg.pin_sync <= 2'h3;
        end
        else
            s_reg <= s_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    // core held in reset outside run and while reset_i is high
    assign core_reset_o = (s_reg.state != RSMC_RUN) || reset_i;
    assign pc_start_o = `RSMC_PC_RESET;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = s_reg.drive_pin;
    assign ram_invalid_o = s_reg.ram_bad;
    assign warn_irq_o = s_reg.irq;
    assign rdata_o = s_reg.rdata;

    // ****************************************
    // checks
    // ****************************************
    sequence full_por_s;
        s_reg.state == RSMC_POR
        ##1 (s_reg.state == RSMC_DELAY && !s_reg.mon_off);
    endsequence

    property pin_reset_p;
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_RUN && pin_low) |=> core_reset_o;
    endproperty

    pin_reset_hold_a: assert property (pin_reset_p)
        else $error("pin low did not reset core");

    por_flag_set_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_DELAY && s_reg.cnt == por_cnt - `RSMC_CNT_W'(1))
        |=> s_reg.por_flag && !core_reset_o)
        else $error("power-on flag not set on exit");

    pin_flag_set_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_HOLD && s_reg.pend_pin && !pin_low
        && !s_reg.pend_vdm) |=> s_reg.pin_flag && !s_reg.por_flag)
        else $error("pin flag wrong after pin reset");

    monitor_drive_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_HOLD && s_reg.pend_vdm
        && !s_reg.above_sync[1]) |=> rst_pin_oe_o && core_reset_o)
        else $error("monitor reset not driving pin");

    sleep_block_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_RUN && sleep_i && !pin_low && !sys_rst
        && !flash_wr_i && !wr_i) |=> s_reg.state == RSMC_RUN)
        else $error("monitor reset during sleep");

    flash_err_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_RUN && flash_wr_i && !s_reg.mon_on)
        |=> core_reset_o && s_reg.pend_ferr)
        else $error("flash write with monitor off not reset");

    keep_select_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_RUN && sys_rst && !s_reg.mon_off)
        |=> $stable(s_reg.mon_on) && $stable(s_reg.mon_sel))
        else $error("software reset changed monitor state");

    monoff_full_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.state == RSMC_RUN && s_reg.mon_off && (pin_low || sys_rst))
        |=> full_por_s)
        else $error("reset with monitor off not full power-on");

    warn_irq_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $fell(s_reg.warn_sync[1]) && s_reg.warn_ie |=> warn_irq_o)
        else $error("warning fall gave no interrupt");

endmodule

`default_nettype wire

// file: bench/rsmc_rail_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// supply rail and external reset circuitry
// ****************************************
module rsmc_rail_model
(
    // commands from the bench
    input wire logic [1:0] level_i,
    input wire logic ext_low_i,
    // device pin driver
    input wire logic pin_oe_i,
    // levels seen by the device
    output logic above_rst_o,
    output logic warn_ok_o,
    output logic pin_n_o
);
    // rail: 0 below reset level, 1 between levels, 2 above warning level
    assign above_rst_o = (level_i != 2'h0);
    assign warn_ok_o = (level_i == 2'h2);
    // pin with pull-up, pulled low by either party
    assign pin_n_o = !(ext_low_i || pin_oe_i);
endmodule

`default_nettype wire

// file: bench/rsmc_reset_ctrl_tb.sv
`include "rsmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// reset and supply monitor bench
// ****************************************
module rsmc_reset_ctrl_tb;
    import rsmc_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] lvl = 2'h2;
    logic ext_low = 1'b0;
    logic sleep = 1'b0;
    logic flash = 1'b0;
    logic settled = 1'b1;
    logic high = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic above, wok, pin_n, pin_o, pin_oe, core_rst, ram_inv, irq;
    logic [7:0] rdata;
    logic [15:0] pc;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    // release delays scaled down by 1000 to keep the run short
    localparam int LOW_CYC = `RSMC_POR_LOW_CYC / 1000;
    localparam int HIGH_CYC = `RSMC_POR_HIGH_CYC / 1000;

    // clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    rsmc_rail_model u_rsmc_rail_model (.level_i(lvl), .ext_low_i(ext_low),
        .pin_oe_i(pin_oe), .above_rst_o(above), .warn_ok_o(wok),
        .pin_n_o(pin_n));

    rsmc_reset_ctrl #(.POR_LOW_CYC(LOW_CYC), .POR_HIGH_CYC(HIGH_CYC))
        u_rsmc_reset_ctrl (.clk_i(clk_i), .reset_i(reset_i),
        .supply_above_reset_level_i(above), .supply_warning_ok_i(wok),
        .supply_high_i(high), .rst_pin_n_i(pin_n), .rst_pin_o(pin_o),
        .rst_pin_oe_o(pin_oe), .sleep_i(sleep), .flash_wr_i(flash),
        .monitor_settled_i(settled), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .core_reset_o(core_rst),
        .pc_start_o(pc), .ram_invalid_o(ram_inv), .warn_irq_o(irq));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    // read data lands in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, m, e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    task automatic cyc_wait(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // bounded wait for core reset to reach a level
    task automatic wait_core(input logic v, input int max, output int k);
        k = 0;
        while (core_rst !== v && k < max)
        begin
            cyc_wait(1);
            k++;
        end
    endtask

    task automatic count_irq(input int k, output int c);
        c = 0;
        repeat (k)
        begin
            cyc_wait(1);
            if (irq === 1'b1)
                c++;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_por;
        @(posedge clk_i);
        reset_i <= 1'b0;
        wait_core(1'b0, LOW_CYC + 20, n);
        chk(n >= LOW_CYC && n <= LOW_CYC + 10, 1);
        chk(pc, `RSMC_PC_RESET);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'hff, 8'he8);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h02, 8'h02);
        rd_chk(8'h00, 8'hff, 8'h00);
        $display("power-on test done");
    endtask

    task automatic t_warn;
        int c;
        @(posedge clk_i);
        lvl <= 2'h1;
        count_irq(10, c);
        chk(c, 1);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'hff, 8'hc8);
        wr_reg(`RSMC_ADDR_SUPPLY_MON, 8'h80);
        lvl <= 2'h2;
        count_irq(5, c);
        @(posedge clk_i);
        lvl <= 2'h1;
        count_irq(10, c);
        chk(c, 0);
        @(posedge clk_i);
        lvl <= 2'h2;
        wr_reg(`RSMC_ADDR_SUPPLY_MON, 8'h88);
        $display("warning test done");
    endtask

    task automatic t_soft;
        wr_reg(`RSMC_ADDR_SUPPLY_MON, 8'h08);
        wr_reg(`RSMC_ADDR_RESET_CAUSE, 8'h12);
        #1;
        chk(core_rst, 1'b1);
        wait_core(1'b0, 100, n);
        chk(core_rst, 1'b0);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'hff, 8'h68);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h12, 8'h10);
        $display("software reset test done");
    endtask

    task automatic t_flash;
        @(posedge clk_i);
        flash <= 1'b1;
        @(posedge clk_i);
        flash <= 1'b0;
        #1;
        chk(core_rst, 1'b1);
        wait_core(1'b0, 100, n);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h40, 8'h40);
        wr_reg(`RSMC_ADDR_SUPPLY_MON, 8'h88);
        wr_reg(`RSMC_ADDR_RESET_CAUSE, 8'h02);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'h80, 8'h80);
        $display("flash error test done");
    endtask

    task automatic t_fail;
        @(posedge clk_i);
        lvl <= 2'h0;
        wait_core(1'b1, 10, n);
        chk(core_rst, 1'b1);
        cyc_wait(20);
        chk({pin_oe, core_rst}, 2'h3);
        @(posedge clk_i);
        lvl <= 2'h2;
        wait_core(1'b0, 50, n);
        chk(core_rst, 1'b0);
        chk(ram_inv, 1'b1);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h02, 8'h02);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'hff, 8'he8);
        $display("power-fail test done");
    endtask

    task automatic t_sleep;
        @(posedge clk_i);
        sleep <= 1'b1;
        lvl <= 2'h0;
        cyc_wait(10);
        chk({pin_oe, core_rst}, 2'h0);
        @(posedge clk_i);
        lvl <= 2'h2;
        ext_low <= 1'b1;
        wait_core(1'b1, 10, n);
        chk(core_rst, 1'b1);
        @(posedge clk_i);
        ext_low <= 1'b0;
        sleep <= 1'b0;
        wait_core(1'b0, 50, n);
        rd_chk(`RSMC_ADDR_SUPPLY_MON, 8'hff, 8'he8);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h03, 8'h01);
        $display("sleep and pin test done");
    endtask

    // deselect on purpose, then select an unsettled monitor
    task automatic t_select;
        wr_reg(`RSMC_ADDR_RESET_CAUSE, 8'h00);
        lvl <= 2'h0;
        cyc_wait(10);
        chk(core_rst, 1'b0);
        @(posedge clk_i);
        lvl <= 2'h2;
        settled <= 1'b0;
        cyc_wait(5);
        wr_reg(`RSMC_ADDR_RESET_CAUSE, 8'h02);
        #1;
        chk(core_rst, 1'b1);
        @(posedge clk_i);
        settled <= 1'b1;
        wait_core(1'b0, 50, n);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h02, 8'h02);
        $display("select test done");
    endtask

    // monitor off turns the next reset into a full power-on, high range
    task automatic t_mode;
        @(posedge clk_i);
        high <= 1'b1;
        wr_reg(`RSMC_ADDR_PWR_MODE, 8'h20);
        rd_chk(`RSMC_ADDR_PWR_MODE, 8'hff, 8'h20);
        wr_reg(`RSMC_ADDR_RESET_CAUSE, 8'h12);
        #1;
        chk(core_rst, 1'b1);
        wait_core(1'b0, HIGH_CYC + 20, n);
        chk(n >= HIGH_CYC && n <= HIGH_CYC + 10, 1);
        rd_chk(`RSMC_ADDR_PWR_MODE, 8'hff, 8'h00);
        rd_chk(`RSMC_ADDR_RESET_CAUSE, 8'h12, 8'h02);
        $display("monitor off test done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        t_por();
        t_warn();
        t_soft();
        t_flash();
        t_fail();
        t_sleep();
        t_select();
        t_mode();
        print_verdict();
    end
endmodule

`default_nettype wire
